/* File: verilog/trghs_port.sv */
`timescale 1ns/1ps
// How it works
// R1: Wrapper keeps input events free of glitches
// R2: Wrapper synchronises trigger outputs when subsystem needs
// R3: Synchroniser is two flops on receiving clock
// R4: Synchronised trigger input costs extra latency
// R5: Mapping path itself stays combinational
// R6: Bypasses only asserted when all subsystems synchronous
// R7: Output event held until it is acknowledged
// R8: Processor disables unit before stopping its clock
// R9: Software turns mapping off around clock stop
// R10: Registers map triggers and software triggers onto channels
// R11: Per-input bypass skips the input synchroniser
// R12: Only a high level counts as event
// R13: Wrapper captures fast-domain triggers until acknowledged
// R14: Wrapper synchronises any acknowledge it needs
// R15: Mapped trigger bit ORs straight onto output
// R16: Without handshake bypass, output held until acknowledge
// R17: Output stays high while mapped bit high
// R18: Software ack write held until mapped bit drops
// R19: Acknowledge synchronised unless its bypass is high
// R20: Handshake bypass makes output follow mapped bit
// R21: Held output ignores later drop of acknowledge driver
// R22: Source holds unacknowledged events at least one cycle
// R23: Debug enable low switches all mapping off
// R24: Reset clears synchronisers, holds and ack holders
module trghs_port #(
  parameter int NUM_TRIG = trghs_pkg::NUM_TRIG,
  parameter int NUM_CHAN = trghs_pkg::NUM_CHAN
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Debug enable
  input wire logic debug_enable_gate,
  // Trigger inputs
  input wire logic [NUM_TRIG-1:0] trigger_in,
  input wire logic [NUM_TRIG-1:0] trig_in_sync_bypass,
  // Trigger outputs
  output logic [NUM_TRIG-1:0] trigger_out,
  input wire logic [NUM_TRIG-1:0] trigger_out_ack,
  input wire logic [NUM_TRIG-1:0] trig_ack_sync_bypass,
  input wire logic [NUM_TRIG-1:0] trig_out_handshake_bypass,
  // Channel side
  output logic [NUM_CHAN-1:0] channel_out,
  input wire logic [NUM_CHAN-1:0] channel_in,
  // Register port
  input wire logic [trghs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [trghs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [trghs_pkg::DATA_W-1:0] reg_rdata
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  logic [NUM_TRIG-1:0] in_s1_ff;
  logic [NUM_TRIG-1:0] in_s2_ff;
  logic [NUM_TRIG-1:0] ack_s1_ff;
  logic [NUM_TRIG-1:0] ack_s2_ff;
  logic dbg_s1_ff;
  logic dbg_s2_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      in_s1_ff <= '0; // R24
      in_s2_ff <= '0;
      ack_s1_ff <= '0;
      ack_s2_ff <= '0;
      dbg_s1_ff <= 1'b0;
      dbg_s2_ff <= 1'b0;
    end else begin
      in_s1_ff <= trigger_in; // R3
      in_s2_ff <= in_s1_ff; // R4
      ack_s1_ff <= trigger_out_ack; // R3
      ack_s2_ff <= ack_s1_ff;
      dbg_s1_ff <= debug_enable_gate;
      dbg_s2_ff <= dbg_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic ctrl_en_ff;
  logic [NUM_CHAN-1:0] app_trig_ff;
  logic [NUM_CHAN-1:0] in_map_ff [NUM_TRIG];
  logic [NUM_CHAN-1:0] out_map_ff [NUM_TRIG];
  logic [NUM_TRIG-1:0] sw_ack_ff;
  logic [NUM_TRIG-1:0] hold_ff;
  logic [trghs_pkg::DATA_W-1:0] rdata_ff;

  wire map_on = ctrl_en_ff & dbg_s2_ff;
  wire [2:0] addr_page = reg_addr[7:5];
  wire [2:0] addr_idx = reg_addr[4:2];
  wire wr_ctrl = reg_wr && (reg_addr == trghs_pkg::CTRL_OFF);
  wire wr_app = reg_wr && (reg_addr == trghs_pkg::APP_TRIG_OFF);
  wire wr_iack = reg_wr && (reg_addr == trghs_pkg::INT_ACK_OFF);
  wire wr_in_map = reg_wr && (addr_page == trghs_pkg::IN_MAP_PAGE) && (reg_addr[1:0] == 2'h0);
  wire wr_out_map = reg_wr && (addr_page == trghs_pkg::OUT_MAP_PAGE) && (reg_addr[1:0] == 2'h0);
  wire [NUM_TRIG-1:0] iack_set = wr_iack ? reg_wdata[NUM_TRIG-1:0] : '0;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_en_ff <= trghs_pkg::CTRL_EN_RST;
      app_trig_ff <= trghs_pkg::APP_TRIG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_ff <= reg_wdata[trghs_pkg::CTRL_EN_BIT];
      end
      if (wr_app) begin
        app_trig_ff <= reg_wdata[NUM_CHAN-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-trigger mapping and output handshake
  // ----------------------------------------------------------------
  logic [NUM_CHAN-1:0] chan_contrib [NUM_TRIG];
  logic [NUM_TRIG-1:0] trig_eff;
  logic [NUM_TRIG-1:0] mapped_trigger;
  logic [NUM_TRIG-1:0] synced_out_ack;
  logic [NUM_TRIG-1:0] ack_total;
  logic [NUM_TRIG-1:0] nxt_trigger_out;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_TRIG; gi++) begin : g_trig
      wire sel = (addr_idx == 3'(gi));
      assign trig_eff[gi] = trig_in_sync_bypass[gi] ? trigger_in[gi] : in_s2_ff[gi]; // R11
      assign chan_contrib[gi] = (trig_eff[gi] == 1'b1) ? in_map_ff[gi] : '0; // R12
      assign mapped_trigger[gi] = map_on & (|(channel_in & out_map_ff[gi])); // R10
      assign synced_out_ack[gi] = trig_ack_sync_bypass[gi] ? trigger_out_ack[gi] : ack_s2_ff[gi]; // R19
      assign ack_total[gi] = synced_out_ack[gi] | sw_ack_ff[gi];
      // Hold loop gated by handshake bypass
      assign nxt_trigger_out[gi] = dbg_s2_ff &
        (mapped_trigger[gi] | (hold_ff[gi] & ~ack_total[gi] & ~trig_out_handshake_bypass[gi])); // R15 R16 R17 R20

      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          in_map_ff[gi] <= trghs_pkg::MAP_RST;
          out_map_ff[gi] <= trghs_pkg::MAP_RST;
          sw_ack_ff[gi] <= 1'b0; // R24
          hold_ff[gi] <= 1'b0;
        end else begin
          if (wr_in_map && sel) begin
            in_map_ff[gi] <= reg_wdata[NUM_CHAN-1:0];
          end
          if (wr_out_map && sel) begin
            out_map_ff[gi] <= reg_wdata[NUM_CHAN-1:0];
          end
          sw_ack_ff[gi] <= iack_set[gi] | (sw_ack_ff[gi] & mapped_trigger[gi]); // R18
          hold_ff[gi] <= nxt_trigger_out[gi] & ~trig_out_handshake_bypass[gi]; // R7 R21
        end
      end
    end
  endgenerate

  logic [NUM_CHAN-1:0] chan_or;
  always_comb begin
    chan_or = app_trig_ff;
    for (int i = 0; i < NUM_TRIG; i++) begin
      chan_or = chan_or | chan_contrib[i];
    end
  end

  // Combinational mapping path, debug gated
  assign channel_out = map_on ? chan_or : '0; // R5 R23
  assign trigger_out = nxt_trigger_out; // R23

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [trghs_pkg::DATA_W-1:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[trghs_pkg::STAT_TRIG_IN_LSB +: NUM_TRIG] = trig_eff;
    status_word[trghs_pkg::STAT_TRIG_OUT_LSB +: NUM_TRIG] = trigger_out;
    status_word[trghs_pkg::STAT_CHAN_IN_LSB +: NUM_CHAN] = channel_in;
  end

  wire in_map_hit = (addr_page == trghs_pkg::IN_MAP_PAGE) && (reg_addr[1:0] == 2'h0) && (addr_idx < NUM_TRIG);
  wire out_map_hit = (addr_page == trghs_pkg::OUT_MAP_PAGE) && (reg_addr[1:0] == 2'h0) && (addr_idx < NUM_TRIG);
  wire [trghs_pkg::DATA_W-1:0] rd_mux =
    (reg_addr == trghs_pkg::CTRL_OFF) ? {{(trghs_pkg::DATA_W-1){1'b0}}, ctrl_en_ff} :
    (reg_addr == trghs_pkg::APP_TRIG_OFF) ? {{(trghs_pkg::DATA_W-NUM_CHAN){1'b0}}, app_trig_ff} :
    (reg_addr == trghs_pkg::INT_ACK_OFF) ? {{(trghs_pkg::DATA_W-NUM_TRIG){1'b0}}, sw_ack_ff} :
    (reg_addr == trghs_pkg::STATUS_OFF) ? status_word :
    in_map_hit ? {{(trghs_pkg::DATA_W-NUM_CHAN){1'b0}}, in_map_ff[addr_idx]} :
    out_map_hit ? {{(trghs_pkg::DATA_W-NUM_CHAN){1'b0}}, out_map_ff[addr_idx]} :
    trghs_pkg::RDATA_RST;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_ff <= trghs_pkg::RDATA_RST;
    end else begin
      rdata_ff <= reg_rd ? rd_mux : trghs_pkg::RDATA_RST;
    end
  end
  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_sw_ack_write;
    wr_iack && reg_wdata[0] && mapped_trigger[0];
  endsequence
  sequence s_ack_held;
    sw_ack_ff[0] [*1] ##1 mapped_trigger[0];
  endsequence

  a_in_sync_two: assert property (1'b1 ##2 1'b1 |-> in_s2_ff == $past(trigger_in, 2)) // R3
    else $error("Input synchroniser depth wrong");
  a_in_bypass_sel: assert property (trig_eff == ((trig_in_sync_bypass & trigger_in) |
    (~trig_in_sync_bypass & $past(trigger_in, 2)))) // R11
    else $error("Input bypass selection wrong");
  a_ack_sync_sel: assert property (synced_out_ack == ((trig_ack_sync_bypass & trigger_out_ack) |
    (~trig_ack_sync_bypass & $past(trigger_out_ack, 2)))) // R19
    else $error("Acknowledge synchroniser selection wrong");
  a_or_path: assert property ((mapped_trigger & ~trigger_out) == '0) // R15
    else $error("Mapped trigger not on output");
  a_bypass_follow: assert property (((trigger_out ^ mapped_trigger) & trig_out_handshake_bypass) == '0) // R20
    else $error("Bypassed output not following map");
  a_hold_until_ack: assert property (1'b1 ##1 ((($past(trigger_out) & ~$past(trig_out_handshake_bypass)) &
    ~ack_total & ~trig_out_handshake_bypass & {NUM_TRIG{dbg_s2_ff}} & ~trigger_out) == '0)) // R16
    else $error("Held output dropped before acknowledge");
  a_sw_ack_hold: assert property (s_sw_ack_write |=> s_ack_held |-> sw_ack_ff[0]) // R18
    else $error("Software acknowledge not held");
  a_debug_off: assert property (!dbg_s2_ff |-> (trigger_out == '0) && (channel_out == '0)) // R23
    else $error("Outputs active with debug disabled");
  a_level_only: assert property (map_on && (trig_eff == '0) && (app_trig_ff == '0) |-> channel_out == '0) // R12
    else $error("Channel raised with no high trigger");
  a_map_to_chan: assert property (map_on && trig_eff[0] |-> (channel_out & in_map_ff[0]) == in_map_ff[0]) // R10
    else $error("Trigger not mapped onto channel");

  // ----------------------------------------------------------------
  // Synchroniser checks
  // ----------------------------------------------------------------
  sequence s_trig0_raw;
    !trig_in_sync_bypass[0] && trigger_in[0];
  endsequence
  sequence s_trig0_quiet;
    !trig_in_sync_bypass[0] && !trigger_in[0] && !in_s1_ff[0] && !in_s2_ff[0];
  endsequence

  a_dbg_sync_two: assert property ( // R3
    1'b1 ##2 1'b1 |-> dbg_s2_ff == $past(debug_enable_gate, 2))
    else $error("Debug enable synchroniser depth wrong");
  a_ack_sync_two: assert property ( // R3
    1'b1 ##2 1'b1 |-> ack_s2_ff == $past(trigger_out_ack, 2))
    else $error("Acknowledge synchroniser depth wrong");
  a_in_sync_late: assert property ( // R4
    s_trig0_raw ##2 !trig_in_sync_bypass[0] |-> trig_eff[0])
    else $error("Synchronised trigger missing after two cycles");
  a_in_sync_first: assert property ( // R4
    s_trig0_quiet ##1 !trig_in_sync_bypass[0] |-> !trig_eff[0])
    else $error("Synchronised trigger seen too early");

  // ----------------------------------------------------------------
  // Output handshake checks
  // ----------------------------------------------------------------
  sequence s_hold_no_ack;
    hold_ff[0] && !ack_total[0] && !trig_out_handshake_bypass[0] && dbg_s2_ff;
  endsequence

  a_hold_tracks_out: assert property ( // R7
    1'b1 |=> hold_ff == ($past(trigger_out) & ~$past(trig_out_handshake_bypass)))
    else $error("Hold latch not following output");
  a_hold_bypass_clr: assert property ( // R20
    1'b1 |=> (hold_ff & $past(trig_out_handshake_bypass)) == '0)
    else $error("Hold latch set under handshake bypass");
  a_hold_keeps: assert property ( // R16
    s_hold_no_ack |-> trigger_out[0])
    else $error("Held output dropped without acknowledge");
  a_ack_releases: assert property ( // R16
    (hold_ff & ack_total & ~mapped_trigger & trigger_out) == '0)
    else $error("Acknowledged output still held");
  a_out_has_source: assert property ( // R17
    (trigger_out & ~mapped_trigger & ~hold_ff) == '0)
    else $error("Output high with no mapped bit or hold");
  a_ack_drop_ignored: assert property ( // R21
    ack_total[0] && !mapped_trigger[0] |=> !hold_ff[0])
    else $error("Hold survives acknowledge");
  a_sw_ack_set: assert property ( // R18
    wr_iack |=> ($past(reg_wdata[NUM_TRIG-1:0]) & ~sw_ack_ff) == '0)
    else $error("Software acknowledge write lost");
  a_sw_ack_clear: assert property ( // R18
    1'b1 |=> (sw_ack_ff & ~$past(mapped_trigger) & ~$past(iack_set)) == '0)
    else $error("Software acknowledge kept after map drop");

  // ----------------------------------------------------------------
  // Mapping checks
  // ----------------------------------------------------------------
  a_chan_map_off: assert property ( // R23
    !map_on |-> channel_out == '0)
    else $error("Channel raised with mapping off");
  a_app_trig_chan: assert property ( // R10
    map_on |-> (channel_out & app_trig_ff) == app_trig_ff)
    else $error("Software trigger not on channel");
  a_out_map_path: assert property ( // R5
    map_on && ((channel_in & out_map_ff[0]) != '0) |-> trigger_out[0])
    else $error("Mapped channel not on trigger output");

  // ----------------------------------------------------------------
  // Register port checks
  // ----------------------------------------------------------------
  sequence s_rd_ctrl;
    reg_rd && (reg_addr == trghs_pkg::CTRL_OFF);
  endsequence

  a_rdata_ctrl: assert property ( // R10
    s_rd_ctrl |=> reg_rdata == {{(trghs_pkg::DATA_W-1){1'b0}}, $past(ctrl_en_ff)})
    else $error("Control read data wrong");
  a_rdata_idle: assert property ( // R10
    !reg_rd |=> reg_rdata == '0)
    else $error("Read data not zero outside read");
  a_wr_ctrl_lands: assert property ( // R10
    wr_ctrl |=> ctrl_en_ff == $past(reg_wdata[trghs_pkg::CTRL_EN_BIT]))
    else $error("Control write lost");
  a_wr_inmap_lands: assert property ( // R10
    wr_in_map && (addr_idx == 3'h0) |=> in_map_ff[0] == $past(reg_wdata[NUM_CHAN-1:0]))
    else $error("Input map write lost");
  a_wr_outmap_lands: assert property ( // R10
    wr_out_map && (addr_idx == 3'h0) |=> out_map_ff[0] == $past(reg_wdata[NUM_CHAN-1:0]))
    else $error("Output map write lost");

endmodule : trghs_port

/* File: verilog/trghs_pkg.sv */
package trghs_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_TRIG = 8;
  localparam int NUM_CHAN = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] APP_TRIG_OFF = 8'h10;
  localparam logic [7:0] INT_ACK_OFF = 8'h14;
  localparam logic [7:0] STATUS_OFF = 8'h18;
  localparam logic [2:0] IN_MAP_PAGE = 3'h1;
  localparam logic [2:0] OUT_MAP_PAGE = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int STAT_TRIG_IN_LSB = 0;
  localparam int STAT_TRIG_OUT_LSB = 8;
  localparam int STAT_CHAN_IN_LSB = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [NUM_CHAN-1:0] MAP_RST = 4'h0;
  localparam logic [NUM_CHAN-1:0] APP_TRIG_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Synchroniser depth
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;
endpackage : trghs_pkg

/* File: verif/trghs_partner.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Far side: channel matrix and subsystem wrapper
// ----------------------------------------------------------------
module trghs_partner (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Control from bench
  input wire logic ack_en,
  input wire logic [trghs_pkg::NUM_CHAN-1:0] ch_req,
  // Trigger side
  input wire logic [trghs_pkg::NUM_TRIG-1:0] trigger_out,
  output logic [trghs_pkg::NUM_TRIG-1:0] trigger_out_ack,
  // Channel side
  output logic [trghs_pkg::NUM_CHAN-1:0] channel_in
);
  logic [trghs_pkg::NUM_TRIG-1:0] ack_d1_ff;
  logic [trghs_pkg::NUM_TRIG-1:0] ack_d2_ff;
  // Matrix event held for as long as the bench requests it
  assign channel_in = ch_req;
  // Wrapper returns acknowledge from its own clocked logic
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_d1_ff <= '0;
      ack_d2_ff <= '0;
    end else begin
      ack_d1_ff <= trigger_out & {trghs_pkg::NUM_TRIG{ack_en}};
      ack_d2_ff <= ack_d1_ff;
    end
  end
  assign trigger_out_ack = ack_d2_ff;
endmodule : trghs_partner

/* File: verif/trghs_port_bench.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module trghs_port_bench;
  logic clock, rst_b, dbg, ack_en, reg_wr, reg_rd;
  logic [7:0] trig_in, in_byp, ack_byp, hs_byp, tout, tack, reg_addr;
  logic [3:0] ch_out, ch_in, ch_req;
  logic [31:0] reg_wdata, reg_rdata;
  int error_cnt = 0;
  int compares = 0;
  trghs_port dut_u (.clock(clock), .rst_b(rst_b), .debug_enable_gate(dbg), .trigger_in(trig_in),
    .trig_in_sync_bypass(in_byp), .trigger_out(tout), .trigger_out_ack(tack), .trig_ack_sync_bypass(ack_byp),
    .trig_out_handshake_bypass(hs_byp), .channel_out(ch_out), .channel_in(ch_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  trghs_partner partner_u (.clock(clock), .rst_b(rst_b), .ack_en(ack_en), .ch_req(ch_req),
    .trigger_out(tout), .trigger_out_ack(tack), .channel_in(ch_in));
  // ----------------------------------------------------------------
  // Bus and timing helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : idle
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    wr(trghs_pkg::CTRL_OFF, 32'h0000_0001);
    wr({trghs_pkg::IN_MAP_PAGE, 5'h00}, 32'h0000_0002);
    wr({trghs_pkg::OUT_MAP_PAGE, 5'h00}, 32'h0000_0001);
    rd(trghs_pkg::CTRL_OFF, 32'h0000_0001);
    rd({trghs_pkg::IN_MAP_PAGE, 5'h00}, 32'h0000_0002);
    rd(8'h80, 32'h0000_0000);
    wr(trghs_pkg::APP_TRIG_OFF, 32'h0000_0008);
    `CHK(ch_out, 4'h8)
    wr(trghs_pkg::APP_TRIG_OFF, 32'h0000_0000);
  endtask : t_regs
  task automatic t_trig_in();
    @(posedge clock); in_byp <= 8'h01; trig_in <= 8'h01;
    #1 `CHK(ch_out, 4'h2)
    @(posedge clock); in_byp <= 8'h00; trig_in <= 8'h00;
    idle(3);
    @(posedge clock); trig_in <= 8'h01;
    #1 `CHK(ch_out, 4'h0)
    idle(1); `CHK(ch_out, 4'h0)
    idle(1); `CHK(ch_out, 4'h2)
    @(posedge clock); trig_in <= 8'h00;
    idle(3);
  endtask : t_trig_in
  task automatic t_hold(input logic ab, input int n_hi);
    @(posedge clock); ack_en <= 1'b1; ack_byp <= {7'h00, ab}; ch_req <= 4'h1;
    #1 `CHK(tout, 8'h01)
    @(posedge clock); ch_req <= 4'h0;
    #1;
    for (int k = 1; k <= n_hi; k++) begin
      `CHK(tout, 8'h01)
      idle(1);
    end
    `CHK(tout, 8'h00)
    idle(3); `CHK(tout, 8'h00)
    idle(4);
  endtask : t_hold
  task automatic t_sticky();
    @(posedge clock); ack_en <= 1'b1; ack_byp <= 8'h00; ch_req <= 4'h1;
    for (int k = 0; k < 6; k++) begin
      idle(1); `CHK(tout, 8'h01)
    end
    @(posedge clock); ch_req <= 4'h0; ack_en <= 1'b0;
    idle(6);
    @(posedge clock); ch_req <= 4'h1;
    @(posedge clock); ch_req <= 4'h0;
    idle(4); `CHK(tout, 8'h01)
    wr(trghs_pkg::INT_ACK_OFF, 32'h0000_0001);
    `CHK(tout, 8'h00)
    idle(3); `CHK(tout, 8'h00)
    @(posedge clock); ch_req <= 4'h1;
    rd(trghs_pkg::STATUS_OFF, 32'h0001_0100);
    wr(trghs_pkg::INT_ACK_OFF, 32'h0000_0001);
    `CHK(tout, 8'h01)
    rd(trghs_pkg::INT_ACK_OFF, 32'h0000_0001);
    @(posedge clock); ch_req <= 4'h0;
    #1 `CHK(tout, 8'h00)
  endtask : t_sticky
  task automatic t_bypass_dbg();
    @(posedge clock); hs_byp <= 8'h01; ch_req <= 4'h1;
    #1 `CHK(tout, 8'h01)
    @(posedge clock); ch_req <= 4'h0;
    #1 `CHK(tout, 8'h00)
    @(posedge clock); dbg <= 1'b0; hs_byp <= 8'h00;
    idle(3);
    @(posedge clock); ch_req <= 4'h1; in_byp <= 8'h01; trig_in <= 8'h01;
    #1 `CHK(tout, 8'h00)
    `CHK(ch_out, 4'h0)
    @(posedge clock); ch_req <= 4'h0; trig_in <= 8'h00; dbg <= 1'b1;
    idle(3);
  endtask : t_bypass_dbg
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    {rst_b, reg_wr, reg_rd, ack_en} = '0;
    {trig_in, in_byp, ack_byp, hs_byp, reg_addr, ch_req, reg_wdata} = '0;
    dbg = 1'b1;
    idle(20);
    `CHK(tout, 8'h00)
    `CHK(ch_out, 4'h0)
    `CHK(reg_rdata, 32'h0000_0000)
    @(posedge clock); rst_b <= 1'b1;
    t_regs();
    t_trig_in();
    t_hold(1'b0, 3);
    t_hold(1'b1, 1);
    t_sticky();
    t_bypass_dbg();
    conclude();
  end
  initial begin
    #20000;
    error_cnt++;
    conclude();
  end
endmodule : trghs_port_bench
